/* File: hw/gpw_consts.vh */
/*
  constants for the four-port bidirectional i/o block with wake-up:
  register offsets, reset values, pin positions.
  assumes inclusion by bare name from the design file.
*/
`ifndef GPW_CONSTS_VH
`define GPW_CONSTS_VH

// register offsets (4-bit address)
`define GPW_OFF_PA_DATA  4'h0
`define GPW_OFF_PA_DIR   4'h1
`define GPW_OFF_PB_DATA  4'h2
`define GPW_OFF_PB_DIR   4'h3
`define GPW_OFF_PC_DATA  4'h4
`define GPW_OFF_PC_DIR   4'h5
`define GPW_OFF_PD_DATA  4'h6
`define GPW_OFF_PD_DIR   4'h7
`define GPW_OFF_BITOP    4'h8
`define GPW_OFF_HALT     4'h9
`define GPW_OFF_IRQ_STAT 4'hA
`define GPW_OFF_IRQ_MASK 4'hB
`define GPW_OFF_CFG_WAKE 4'hC
`define GPW_OFF_CFG_PULL 4'hD
`define GPW_OFF_CFG_SHRC 4'hE
`define GPW_OFF_CFG_SHR  4'hF

// reset values
`define GPW_RST_LATCH 8'hFF
`define GPW_RST_DIR   8'hFF
`define GPW_RST_ZERO  8'h00

// bit-op word: [2:0] bit index, [4:3] port, [5] set(1)/clear(0),
// [6] target direction(1)/data(0)
`define GPW_BOP_IDX_HI 2
`define GPW_BOP_IDX_LO 0
`define GPW_BOP_PORT_HI 4
`define GPW_BOP_PORT_LO 3
`define GPW_BOP_SET 5
`define GPW_BOP_DIR 6

// pin-share config word bits
`define GPW_SHR_INT 0
`define GPW_INT_PIN 5
// converter pins: count and position of their share bits in the word
`define GPW_RCO_PINS 4
`define GPW_RCO_SHR_LO 4

// status bits
`define GPW_ST_WAKE 0
`define GPW_ST_INT  1

// read data when nothing selected
`define GPW_RD_NONE 8'h00

`endif

/* File: hw/gpw_port.v */
/*
  four 8-bit bidirectional ports with direction registers, read-modify-write
  bit operations, pull-up enables, pin sharing and wake-up from halt.
  assumes pins synchronous to mclk; pull-ups and pad muxing realised outside
  from the enables given here; the core stops its clock on clk_run low.
*/
// Chosen here: the address map and the strobed register port.
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - direction bit one makes the pin an input, readable directly
// - direction bit zero drives the pin push-pull from the latch bit unless the pin is shared
// - reading an output bit returns the latch, not the pin level
// - written output data holds until the latch is written again
// - input reads sample the live pin, nothing latched before
// - reset sets all data latches and direction registers to ones
// - switching to output without a data write drives high
// - bit set/clear reads the port, alters one bit, writes it back
// - halt stops the clock until an enabled first-port input pin falls
// - wake-up enable is per pin for all eight first-port pins
// - pull-up on only when pin is input and its port option set
// - interrupt input shares first-port bit 5, needs option and input
// - analog switch lines take third-port pins by config bits
// - converter pins take fourth-port low four pins by config bits
`timescale 1ns/1ps
`default_nettype none
`include "gpw_consts.vh"

module gpw_port #(
  parameter integer W = 8,
  parameter integer ANALOG_LINES = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [W-1:0] pa_in,
  output reg [W-1:0] pa_out,
  output reg [W-1:0] pa_oe,
  output reg [W-1:0] pa_pull,
  input wire [W-1:0] pb_in,
  output reg [W-1:0] pb_out,
  output reg [W-1:0] pb_oe,
  output reg [W-1:0] pb_pull,
  input wire [W-1:0] pc_in,
  output reg [W-1:0] pc_out,
  output reg [W-1:0] pc_oe,
  output reg [W-1:0] pc_pull,
  input wire [W-1:0] pd_in,
  output reg [W-1:0] pd_out,
  output reg [W-1:0] pd_oe,
  output reg [W-1:0] pd_pull,
  output reg [W-1:0] analog_switch_lines,
  output reg [3:0] rc_oscillator_converter,
  output reg ext_int_n,
  output reg clk_run,
  output reg irq
);

  //////////////////////////////////////////////////////////////////////////
  // registers
  reg [W-1:0] first_port_latch_reg;
  reg [W-1:0] second_port_latch_reg;
  reg [W-1:0] third_port_latch_reg;
  reg [W-1:0] fourth_port_latch_reg;
  reg [W-1:0] first_port_direction_reg;
  reg [W-1:0] second_port_direction_alt_reg;
  reg [W-1:0] third_port_direction_reg;
  reg [W-1:0] fourth_port_direction_reg;
  reg [W-1:0] wake_en_reg;
  reg [3:0] pull_en_reg;
  reg [W-1:0] shr_c_reg;
  reg [7:0] shr_reg;
  reg [1:0] stat_reg;
  reg [1:0] mask_reg;
  reg [W-1:0] pa_prev_reg;
  reg int_prev_reg;
  reg halted_reg;

  //////////////////////////////////////////////////////////////////////////
  // port read values: input bits live, output bits from latch
  wire [W-1:0] pa_view;
  wire [W-1:0] pb_view;
  wire [W-1:0] pc_view;
  wire [W-1:0] pd_view;
  assign pa_view = (first_port_direction_reg & pa_in) |
    (~first_port_direction_reg & first_port_latch_reg);
  assign pb_view = (second_port_direction_alt_reg & pb_in) |
    (~second_port_direction_alt_reg & second_port_latch_reg);
  assign pc_view = (third_port_direction_reg & pc_in) |
    (~third_port_direction_reg & third_port_latch_reg);
  assign pd_view = (fourth_port_direction_reg & pd_in) |
    (~fourth_port_direction_reg & fourth_port_latch_reg);

  //////////////////////////////////////////////////////////////////////////
  // bit operation: read whole port, change one bit, write back
  wire bop_wr;
  wire [2:0] bop_idx;
  wire [1:0] bop_port;
  wire bop_set;
  wire bop_dir;
  reg [W-1:0] bop_src;
  reg [W-1:0] bop_val;
  assign bop_wr = wr && (addr == `GPW_OFF_BITOP);
  assign bop_idx = wdata[`GPW_BOP_IDX_HI:`GPW_BOP_IDX_LO];
  assign bop_port = wdata[`GPW_BOP_PORT_HI:`GPW_BOP_PORT_LO];
  assign bop_set = wdata[`GPW_BOP_SET];
  assign bop_dir = wdata[`GPW_BOP_DIR];

  always @* begin
    case ({bop_dir, bop_port})
      3'h0: bop_src = pa_view;
      3'h1: bop_src = pb_view;
      3'h2: bop_src = pc_view;
      3'h3: bop_src = pd_view;
      3'h4: bop_src = first_port_direction_reg;
      3'h5: bop_src = second_port_direction_alt_reg;
      3'h6: bop_src = third_port_direction_reg;
      default: bop_src = fourth_port_direction_reg;
    endcase
    bop_val = bop_src;
    bop_val[bop_idx] = bop_set;
  end

  //////////////////////////////////////////////////////////////////////////
  // wake and interrupt events
  wire [W-1:0] fall_pa;
  wire wake_ev;
  wire int_en;
  wire int_fall;
  wire stat_rd;
  assign fall_pa = pa_prev_reg & ~pa_in & wake_en_reg &
    first_port_direction_reg;
  assign wake_ev = halted_reg && (|fall_pa);
  assign int_en = shr_reg[`GPW_SHR_INT] &
    first_port_direction_reg[`GPW_INT_PIN];
  assign int_fall = int_en && int_prev_reg && !pa_in[`GPW_INT_PIN];
  assign stat_rd = rd && (addr == `GPW_OFF_IRQ_STAT);

  //////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge mclk) begin
    if (!rst_n) begin
      first_port_latch_reg <= `GPW_RST_LATCH;
      second_port_latch_reg <= `GPW_RST_LATCH;
      third_port_latch_reg <= `GPW_RST_LATCH;
      fourth_port_latch_reg <= `GPW_RST_LATCH;
      first_port_direction_reg <= `GPW_RST_DIR;
      second_port_direction_alt_reg <= `GPW_RST_DIR;
      third_port_direction_reg <= `GPW_RST_DIR;
      fourth_port_direction_reg <= `GPW_RST_DIR;
      wake_en_reg <= `GPW_RST_ZERO;
      pull_en_reg <= 4'h0;
      shr_c_reg <= `GPW_RST_ZERO;
      shr_reg <= `GPW_RST_ZERO;
      mask_reg <= 2'h0;
      halted_reg <= 1'b0;
    end else begin
      // latches change only on a write, else hold
      if (wr) begin
        case (addr)
          `GPW_OFF_PA_DATA: first_port_latch_reg <= wdata;
          `GPW_OFF_PA_DIR: first_port_direction_reg <= wdata;
          `GPW_OFF_PB_DATA: second_port_latch_reg <= wdata;
          `GPW_OFF_PB_DIR: second_port_direction_alt_reg <= wdata;
          `GPW_OFF_PC_DATA: third_port_latch_reg <= wdata;
          `GPW_OFF_PC_DIR: third_port_direction_reg <= wdata;
          `GPW_OFF_PD_DATA: fourth_port_latch_reg <= wdata;
          `GPW_OFF_PD_DIR: fourth_port_direction_reg <= wdata;
          `GPW_OFF_IRQ_MASK: mask_reg <= wdata[1:0];
          `GPW_OFF_CFG_WAKE: wake_en_reg <= wdata;
          `GPW_OFF_CFG_PULL: pull_en_reg <= wdata[3:0];
          `GPW_OFF_CFG_SHRC: shr_c_reg <= wdata;
          `GPW_OFF_CFG_SHR: shr_reg <= wdata;
          default: ;
        endcase
      end
      if (bop_wr) begin
        case ({bop_dir, bop_port})
          3'h0: first_port_latch_reg <= bop_val;
          3'h1: second_port_latch_reg <= bop_val;
          3'h2: third_port_latch_reg <= bop_val;
          3'h3: fourth_port_latch_reg <= bop_val;
          3'h4: first_port_direction_reg <= bop_val;
          3'h5: second_port_direction_alt_reg <= bop_val;
          3'h6: third_port_direction_reg <= bop_val;
          default: fourth_port_direction_reg <= bop_val;
        endcase
      end
      // halt write stops the clock; an enabled falling input pin restarts it
      if (wake_ev)
        halted_reg <= 1'b0;
      else if (wr && addr == `GPW_OFF_HALT)
        halted_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge history and sticky status; set beats read-clear
  always @(posedge mclk) begin
    if (!rst_n) begin
      pa_prev_reg <= `GPW_RST_ZERO;
      int_prev_reg <= 1'b0;
      stat_reg <= 2'h0;
    end else begin
      pa_prev_reg <= pa_in;
      int_prev_reg <= pa_in[`GPW_INT_PIN];
      stat_reg[`GPW_ST_WAKE] <= wake_ev |
        (stat_reg[`GPW_ST_WAKE] & ~stat_rd);
      stat_reg[`GPW_ST_INT] <= int_fall |
        (stat_reg[`GPW_ST_INT] & ~stat_rd);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= `GPW_RD_NONE;
    end else if (rd) begin
      case (addr)
        `GPW_OFF_PA_DATA: rdata <= pa_view;
        `GPW_OFF_PA_DIR: rdata <= first_port_direction_reg;
        `GPW_OFF_PB_DATA: rdata <= pb_view;
        `GPW_OFF_PB_DIR: rdata <= second_port_direction_alt_reg;
        `GPW_OFF_PC_DATA: rdata <= pc_view;
        `GPW_OFF_PC_DIR: rdata <= third_port_direction_reg;
        `GPW_OFF_PD_DATA: rdata <= pd_view;
        `GPW_OFF_PD_DIR: rdata <= fourth_port_direction_reg;
        `GPW_OFF_HALT: rdata <= {7'h00, halted_reg};
        `GPW_OFF_IRQ_STAT: rdata <= {6'h00, stat_reg};
        `GPW_OFF_IRQ_MASK: rdata <= {6'h00, mask_reg};
        `GPW_OFF_CFG_WAKE: rdata <= wake_en_reg;
        `GPW_OFF_CFG_PULL: rdata <= {4'h0, pull_en_reg};
        `GPW_OFF_CFG_SHRC: rdata <= shr_c_reg;
        `GPW_OFF_CFG_SHR: rdata <= shr_reg;
        default: rdata <= `GPW_RD_NONE;
      endcase
    end else begin
      rdata <= `GPW_RD_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pad outputs, registered; shared pins released from i/o drive
  wire [W-1:0] pc_shr;
  wire [W-1:0] pd_shr;
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_shr
      assign pc_shr[g] = (g < ANALOG_LINES) ? shr_c_reg[g] : 1'b0;
      // only the low pins have a converter share bit; a guarded select
      // keeps the upper pins from indexing past the share word
      if (g < `GPW_RCO_PINS) begin : g_rco
        assign pd_shr[g] = shr_reg[g + `GPW_RCO_SHR_LO];
      end else begin : g_io
        assign pd_shr[g] = 1'b0;
      end
    end
  endgenerate

  always @(posedge mclk) begin
    if (!rst_n) begin
      pa_out <= `GPW_RST_LATCH;
      pb_out <= `GPW_RST_LATCH;
      pc_out <= `GPW_RST_LATCH;
      pd_out <= `GPW_RST_LATCH;
      pa_oe <= `GPW_RST_ZERO;
      pb_oe <= `GPW_RST_ZERO;
      pc_oe <= `GPW_RST_ZERO;
      pd_oe <= `GPW_RST_ZERO;
      pa_pull <= `GPW_RST_ZERO;
      pb_pull <= `GPW_RST_ZERO;
      pc_pull <= `GPW_RST_ZERO;
      pd_pull <= `GPW_RST_ZERO;
      analog_switch_lines <= `GPW_RST_ZERO;
      rc_oscillator_converter <= 4'h0;
      ext_int_n <= 1'b1;
      clk_run <= 1'b1;
      irq <= 1'b0;
    end else begin
      pa_out <= first_port_latch_reg;
      pb_out <= second_port_latch_reg;
      pc_out <= third_port_latch_reg;
      pd_out <= fourth_port_latch_reg;
      pa_oe <= ~first_port_direction_reg;
      pb_oe <= ~second_port_direction_alt_reg;
      pc_oe <= ~third_port_direction_reg & ~pc_shr;
      pd_oe <= ~fourth_port_direction_reg & ~pd_shr;
      pa_pull <= first_port_direction_reg & {W{pull_en_reg[0]}};
      pb_pull <= second_port_direction_alt_reg & {W{pull_en_reg[1]}};
      pc_pull <= third_port_direction_reg & {W{pull_en_reg[2]}};
      pd_pull <= fourth_port_direction_reg & {W{pull_en_reg[3]}};
      analog_switch_lines <= pc_shr & pc_in;
      rc_oscillator_converter <= pd_shr[3:0] & pd_in[3:0];
      ext_int_n <= int_en ? pa_in[`GPW_INT_PIN] : 1'b1;
      clk_run <= ~(halted_reg & ~wake_ev) &
        ~(wr && addr == `GPW_OFF_HALT);
      irq <= |(stat_reg & mask_reg);
    end
  end

endmodule // gpw_port
`default_nettype wire

/* File: verification/gpw_port_monitor.sv */
/* assertions on the pins and strobes of the four-port i/o block.
   assumes a bind onto gpw_port, one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module gpw_port_monitor #(parameter integer W = 8) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [W-1:0] pa_in,
  input wire logic [W-1:0] pa_out,
  input wire logic [W-1:0] pa_oe,
  input wire logic [W-1:0] pa_pull,
  input wire logic [W-1:0] pc_in,
  input wire logic [W-1:0] pd_in,
  input wire logic [W-1:0] analog_switch_lines,
  input wire logic [3:0] rc_oscillator_converter,
  input wire logic ext_int_n,
  input wire logic clk_run
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_RST_STATE: assert property ($rose(rst_n) |->
    pa_out == 8'hFF && pa_oe == 8'h00 && clk_run) else $error("bad reset");
  AST_LATCH_OUT: assert property (wr && addr == 4'h0 |->
    ##2 pa_out == $past(wdata, 2)) else $error("latch not on pad");
  AST_DIR_OE: assert property (wr && addr == 4'h1 |->
    ##2 pa_oe == ~$past(wdata, 2)) else $error("direction not on enable");
  AST_PULL_IN: assert property ((pa_pull & pa_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  // a write just before the read would still be in flight to the pads
  AST_READ_VIEW: assert property (
    rd && addr == 4'h0 && !$past(wr) |=>
    rdata == (($past(pa_out) & $past(pa_oe)) |
    ($past(pa_in) & ~$past(pa_oe))))
    else $error("port read view wrong");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  AST_HALT_STOP: assert property (
    wr && addr == 4'h9 |-> ##[1:2] !clk_run)
    else $error("halt did not stop clock");
  AST_HALT_HOLD: assert property (
    !clk_run && $stable(pa_in) ##1
    !clk_run && $stable(pa_in) |=> !clk_run)
    else $error("woke with no edge");
  AST_EXT_INT: assert property (!ext_int_n |-> !$past(pa_in[5]))
    else $error("interrupt line low with pin high");
  AST_SHARE_PINS: assert property (
    (analog_switch_lines & ~$past(pc_in)) == 8'h00 &&
    ({4'h0, rc_oscillator_converter} & ~$past(pd_in)) == 8'h00)
    else $error("shared line not from its pin");
  cover property (rd && addr == 4'h0);
  cover property ($rose(clk_run));
  cover property (!ext_int_n);
endmodule // gpw_port_monitor
bind gpw_port gpw_port_monitor #(.W(W)) i_gpw_port_monitor (.mclk(mclk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
  .pa_pull(pa_pull), .pc_in(pc_in), .pd_in(pd_in),
  .analog_switch_lines(analog_switch_lines), .ext_int_n(ext_int_n),
  .rc_oscillator_converter(rc_oscillator_converter), .clk_run(clk_run));
`default_nettype wire

/* File: verification/gpw_pin_model.sv */
/* external switches and weak pull-up on the pads of one port.
   assumes the port's latch, enable and pull-up lines at the pad. */
`timescale 1ns/1ps
`default_nettype none
module gpw_pin_model (
  input wire logic [7:0] drv,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull,
  input wire logic [7:0] sw,
  input wire logic [7:0] sw_en,
  output logic [7:0] pin
);
  // a floating line without pull-up shows the inverse of the latch, never a stale match
  assign pin = (oe & drv) | (~oe & sw_en & sw)
    | (~oe & ~sw_en & (pull | ~drv));
endmodule // gpw_pin_model
`default_nettype wire

/* File: verification/test_bidirectional_port_with_wakeup.sv */
/* self-checking bench for the four-port i/o block with wake-up.
   assumes the pin model on every port and the bound monitor. */
`timescale 1ns/1ps
`default_nettype none
module test_bidirectional_port_with_wakeup;
  logic mclk, rst_n, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, sa, sc, sd, d;
  int err_count, compares;
  wire [7:0] rdata, pa_in, pa_out, pa_oe, pa_pull, pb_in, pb_out, pb_oe;
  wire [7:0] pb_pull, pc_in, pc_out, pc_oe, pc_pull, pd_in, pd_out, pd_oe;
  wire [7:0] pd_pull, asl;
  wire [3:0] rco;
  wire ext_int_n, clk_run, irq;
  gpw_port i_gpw_port (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .pa_pull(pa_pull), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull(pb_pull), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe(pc_oe), .pc_pull(pc_pull), .pd_in(pd_in),
    .pd_out(pd_out), .pd_oe(pd_oe), .pd_pull(pd_pull), .irq(irq),
    .analog_switch_lines(asl), .rc_oscillator_converter(rco),
    .ext_int_n(ext_int_n), .clk_run(clk_run));
  gpw_pin_model i_pa (.drv(pa_out), .oe(pa_oe), .pull(pa_pull), .sw(sa),
    .sw_en(8'hFF), .pin(pa_in));
  gpw_pin_model i_pb (.drv(pb_out), .oe(pb_oe), .pull(pb_pull), .sw(8'h00),
    .sw_en(8'h00), .pin(pb_in));
  gpw_pin_model i_pc (.drv(pc_out), .oe(pc_oe), .pull(pc_pull), .sw(sc),
    .sw_en(8'hFF), .pin(pc_in));
  gpw_pin_model i_pd (.drv(pd_out), .oe(pd_oe), .pull(pd_pull), .sw(sd),
    .sw_en(8'hFF), .pin(pd_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // bounded wait on the core clock gate; running out ends the run
  task automatic wait_run(input logic v);
    for (int n = 0; n < 20 && clk_run !== v; n++) begin
      @(posedge mclk);
      #1;
    end
    chk({7'h00, clk_run}, {7'h00, v});
    if (clk_run !== v) close_out();
  endtask
  task automatic t_reset;
    chk(pa_out, 8'hFF);
    chk(pa_oe, 8'h00);
    rreg(4'h1, d);
    chk(d, 8'hFF);
    rreg(4'h0, d);
    chk(d, 8'hA5);
  endtask
  task automatic t_dir_and_read;
    wreg(4'h1, 8'h0F);
    chk(pa_oe, 8'hF0);
    chk(pa_in & 8'hF0, 8'hF0);
    wreg(4'h0, 8'h3C);
    chk(pa_in & 8'hF0, 8'h30);
    rreg(4'h0, d);
    chk(d, 8'h35);
    @(posedge mclk) sa <= 8'h5A;
    rreg(4'h0, d);
    chk(d, 8'h3A);
  endtask
  task automatic t_bit_ops;
    wreg(4'h8, 8'h27);
    chk(pa_out, 8'hBA);
    wreg(4'h8, 8'h40);
    chk(pa_oe, 8'hF1);
    wreg(4'h8, 8'h4A);
    chk(pb_oe, 8'h04);
    chk(pb_out, 8'hFF);
    wreg(4'hD, 8'h03);
    chk(pa_pull, 8'h0E);
    chk(pc_pull, 8'h00);
    chk(pb_pull, 8'hFB);
    chk(pd_pull, 8'h00);
    rreg(4'h2, d);
    chk(d, 8'hFF);
  endtask
  task automatic t_wake;
    wreg(4'hC, 8'h03);
    wreg(4'hB, 8'h01);
    wreg(4'h9, 8'h00);
    wait_run(1'b0);
    @(posedge mclk) sa <= 8'h52;
    repeat (4) @(posedge mclk);
    #1 chk({7'h00, clk_run}, 8'h00);
    @(posedge mclk) sa <= 8'h50;
    wait_run(1'b1);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq}, 8'h01);
    rreg(4'hA, d);
    chk(d & 8'h01, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq}, 8'h00);
  endtask
  task automatic t_share;
    @(posedge mclk) sc <= 8'h3C;
    sd <= 8'h0A;
    wreg(4'h1, 8'hFF);
    wreg(4'hE, 8'hF0);
    wreg(4'hF, 8'h31);
    wreg(4'h5, 8'h00);
    wreg(4'h7, 8'h00);
    chk(pc_oe, 8'h0F);
    chk(pd_oe, 8'hFC);
    chk({7'h00, ext_int_n}, 8'h00);
    chk(asl, 8'h30);
    chk({4'h0, rco}, 8'h02);
    @(posedge mclk) sa <= 8'h70;
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, ext_int_n}, 8'h01);
    chk(pa_out, 8'hBA);
    @(posedge mclk) sa <= 8'h50;
    repeat (2) @(posedge mclk);
    rreg(4'hA, d);
    chk(d, 8'h02);
  endtask
  task automatic t_rerst;
    @(posedge mclk) rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk(pa_out, 8'hFF);
    chk(pd_oe, 8'h00);
    rreg(4'h5, d);
    chk(d, 8'hFF);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    sa = 8'hA5;
    sc = 8'h00;
    sd = 8'h00;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_dir_and_read();
    t_bit_ops();
    t_wake();
    t_share();
    t_rerst();
    close_out();
  end
endmodule // test_bidirectional_port_with_wakeup
`default_nettype wire
